// >>> hw/cbr_console_ctrl.sv
// Button, relay and headphone control logic of the announcer console.
// Assumes pushbuttons on active-low pins, rotary controls sampled by an ADC
// on ref_clk, and software access over AXI4-Lite.
//
// What this block does
// - Two-bit mode; push-to-mute mutes while held.
// - Push-to-talk: main active only while held.
// - Alternate action toggles per press, starts muted.
// - Main hybrid: hold is momentary, tap toggles.
// - Talkback 1 push-to-talk or hybrid select.
// - Talkback 1 hybrid: hold momentary, tap toggles.
// - Talkback 1 muted after power-up.
// - Talkback 2 push-to-talk or hybrid select.
// - Talkback 2 hybrid, muted after power-up.
// - Talkback 2 audio follows its button state.
// - Disabled talkback 2 still drives relay only.
// - Relay disabled mode never changes state.
// - Relay follows main output status.
// - Relay follows talkback 1 button state.
// - Relay follows talkback 2 button state.
// - Setting changes take effect immediately.
// - Dual mode: each control sets one channel.
// - Stereo mode: left level, right balance.
// - Normal dual: left control governs left channel.
// - Normal stereo: counterclockwise balance favours left.
// - Reverse orientation swaps channel assignments.
`timescale 1ns/1ps
`default_nettype none

module cbr_console_ctrl
  import cbr_pkg::*;
#(
  parameter int unsigned TICK_LEN = cbr_pkg::TICK_CYCLES
) (
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  // Pushbutton pins, low while pressed.
  input  wire logic                      main_button_n,
  input  wire logic                      talkback1_button_n,
  input  wire logic                      talkback2_button_n,
  // Rotary control positions, 0 fully counterclockwise.
  input  wire logic [cbr_pkg::POT_W-1:0] left_pot,
  input  wire logic [cbr_pkg::POT_W-1:0] right_pot,
  // Outputs.
  output logic                           main_active,
  output logic                           talkback1_active,
  output logic                           talkback2_active,
  output logic                           relay_energize,
  output logic [cbr_pkg::POT_W-1:0]      hp_left_gain,
  output logic [cbr_pkg::POT_W-1:0]      hp_right_gain,
  // AXI4-Lite slave.
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import cbr_pkg::*;

  // A divider shorter than two cycles cannot make a one-cycle tick.
  if (TICK_LEN < 2) begin : g_bad_tick
    $error("TICK_LEN must be at least 2");
  end

  localparam int unsigned TW = $clog2(TICK_LEN);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg, next_cfg;
  logic             next_bvalid, next_rvalid, wr_go, rd_go;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata, status_word;

  // Address and data are taken together, only while no response waits.
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  // Writes land in the config word at once, so every mode follows live. Status
  // and gain words are read-only; a write there is dropped with OKAY.
  always_comb begin
    next_cfg    = cfg;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      if (s_axi_awaddr[7:2] == CFG_OFFSET[7:2]) begin
        if (s_axi_wstrb[0]) next_cfg[7:0] = s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) next_cfg[CFG_W-1:8] = s_axi_wdata[CFG_W-1:8];
      end else if (s_axi_awaddr[7:2] != STATUS_OFFSET[7:2] &&
                   s_axi_awaddr[7:2] != GAIN_OFFSET[7:2]) begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr[7:2])
        CFG_OFFSET[7:2]:    next_rdata = {{(32-CFG_W){1'b0}}, cfg};
        STATUS_OFFSET[7:2]: next_rdata = status_word;
        GAIN_OFFSET[7:2]:   next_rdata = {16'h0000, hp_right_gain, hp_left_gain};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus state registers.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg          <= CFG_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      cfg          <= next_cfg;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end

  cbr_main_mode_e  main_mode;
  cbr_relay_mode_e relay_mode;
  assign main_mode  = cbr_main_mode_e'(cfg[CFG_MAIN_LSB +: 2]);
  assign relay_mode = cbr_relay_mode_e'(cfg[CFG_RELAY_LSB +: 2]);

  // ----------------------------------------------------------------
  // Slow tick
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic          tick;

  // The 1 ms enable keeps debounce and hold counters a few bits wide.
  always_comb begin
    tick          = (tick_cnt == TW'(TICK_LEN - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) tick_cnt <= '0;
    else tick_cnt <= next_tick_cnt;
  end

  // ----------------------------------------------------------------
  // Buttons: synchronise, debounce, time, latch
  // ----------------------------------------------------------------
  logic [2:0] pin_pressed, pressed, press_edge, release_edge, is_long, latch;
  logic [2:0] latch_sel;    // Button uses a latched state at all.
  logic [2:0] alt_sel;      // Toggle on every press.

  assign pin_pressed = {~talkback2_button_n, ~talkback1_button_n, ~main_button_n};
  assign alt_sel     = {2'b00, main_mode == CBR_MAIN_ALT};
  assign latch_sel   = {cfg[CFG_TB2_HYB], cfg[CFG_TB1_HYB],
                        main_mode == CBR_MAIN_ALT || main_mode == CBR_MAIN_HYB};

  for (genvar i = 0; i < 3; i++) begin : g_btn
    logic [1:0]            sync;
    logic                  db, next_db, next_latch;
    logic [DEB_CNT_W-1:0]  deb_cnt, next_deb_cnt;
    logic [HOLD_CNT_W-1:0] hold_cnt, next_hold_cnt;

    // A changed level must stay put for the whole debounce time; tap versus
    // hold is judged on the clean level. Leaving a latching mode clears the
    // latch so a later return starts muted.
    always_comb begin
      next_db       = db;
      next_deb_cnt  = '0;
      next_hold_cnt = hold_cnt;
      next_latch    = latch[i];
      if (sync[1] != db) begin
        next_deb_cnt = deb_cnt;
        if (tick) begin
          if (deb_cnt == DEB_TICKS - 1'b1) begin
            next_db      = sync[1];
            next_deb_cnt = '0;
          end else begin
            next_deb_cnt = deb_cnt + 1'b1;
          end
        end
      end
      if (!db) next_hold_cnt = '0;
      else if (tick && !is_long[i]) next_hold_cnt = hold_cnt + 1'b1;
      if (!latch_sel[i]) next_latch = 1'b0;
      else if (alt_sel[i] && press_edge[i]) next_latch = ~latch[i];
      else if (!alt_sel[i] && release_edge[i] && !is_long[i]) begin
        next_latch = ~latch[i];
      end
      // A long press releases with the latch untouched.
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        sync     <= 2'b00;
        db       <= 1'b0;
        deb_cnt  <= '0;
        hold_cnt <= '0;
        latch[i] <= 1'b0;
      end else begin
        sync     <= {sync[0], pin_pressed[i]};
        db       <= next_db;
        deb_cnt  <= next_deb_cnt;
        hold_cnt <= next_hold_cnt;
        latch[i] <= next_latch;
      end
    end

    assign pressed[i]      = db;
    assign press_edge[i]   = next_db && !db;
    assign release_edge[i] = !next_db && db;
    assign is_long[i]      = (hold_cnt == HOLD_TICKS);
  end

  // ----------------------------------------------------------------
  // Output states and relay
  // ----------------------------------------------------------------
  logic tb2_state, next_relay;

  // Hybrid buttons are live while held and otherwise show their latch.
  always_comb begin
    case (main_mode)
      CBR_MAIN_MUTE: main_active = !pressed[0];
      CBR_MAIN_PTT:  main_active = pressed[0];
      CBR_MAIN_ALT:  main_active = latch[0];
      CBR_MAIN_HYB:  main_active = pressed[0] || latch[0];
      default:       main_active = 1'b0;
    endcase
    talkback1_active = pressed[1] || latch[1];
    // With the function off the button only matters when the relay follows it.
    tb2_state = (cfg[CFG_TB2_EN] || relay_mode == CBR_RELAY_TB2) &&
                (pressed[2] || latch[2]);
    talkback2_active = cfg[CFG_TB2_EN] && tb2_state;
    case (relay_mode)
      CBR_RELAY_OFF:  next_relay = 1'b0;
      CBR_RELAY_MAIN: next_relay = main_active;
      CBR_RELAY_TB1:  next_relay = talkback1_active;
      CBR_RELAY_TB2:  next_relay = tb2_state;
      default:        next_relay = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) relay_energize <= 1'b0;
    else relay_energize <= next_relay;
  end

  assign status_word = {21'h000000, pressed, 3'h0, relay_energize, talkback2_active,
                        tb2_state, talkback1_active, main_active};

  // ----------------------------------------------------------------
  // Headphone controls
  // ----------------------------------------------------------------
  logic [POT_W-1:0]   fac_ccw;   // Scale of the side favoured counterclockwise.
  logic [POT_W-1:0]   fac_cw, next_hp_left, next_hp_right;
  logic [2*POT_W-1:0] prod_ccw, prod_cw;

  // Balance centre leaves both sides full; each half cuts one side linearly.
  always_comb begin
    fac_ccw  = (right_pot <= 8'h80) ? 8'hFF : {~right_pot[POT_W-2:0], 1'b0};
    fac_cw   = (right_pot >= 8'h7F) ? 8'hFF : {right_pot[POT_W-2:0], 1'b0};
    prod_ccw = left_pot * fac_ccw;
    prod_cw  = left_pot * fac_cw;
    if (!cfg[CFG_STEREO]) begin
      next_hp_left  = cfg[CFG_REVERSE] ? right_pot : left_pot;
      next_hp_right = cfg[CFG_REVERSE] ? left_pot : right_pot;
    end else begin
      next_hp_left  = cfg[CFG_REVERSE] ? prod_cw[2*POT_W-1:POT_W]
                                       : prod_ccw[2*POT_W-1:POT_W];
      next_hp_right = cfg[CFG_REVERSE] ? prod_ccw[2*POT_W-1:POT_W]
                                       : prod_cw[2*POT_W-1:POT_W];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hp_left_gain  <= '0;
      hp_right_gain <= '0;
    end else begin
      hp_left_gain  <= next_hp_left;
      hp_right_gain <= next_hp_right;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ptt_main;
    @(posedge ref_clk) disable iff (sys_rst)
      (main_mode == CBR_MAIN_PTT) |-> (main_active == pressed[0]);
  endproperty
  a_ptt_main: assert property (p_ptt_main) else $error("main not following push-to-talk");
  property p_alt_toggle;
    @(posedge ref_clk) disable iff (sys_rst)
      (main_mode == CBR_MAIN_ALT && press_edge[0] && !s_axi_bvalid && !wr_go)
        |=> (main_active != $past(main_active));
  endproperty
  a_alt_toggle: assert property (p_alt_toggle) else $error("alternate press did not toggle");
  property p_tap_toggles;
    @(posedge ref_clk) disable iff (sys_rst)
      (latch_sel[1] && release_edge[1] && !is_long[1] && !wr_go) |=> (latch[1] != $past(latch[1]));
  endproperty
  a_tap_toggles: assert property (p_tap_toggles) else $error("tap did not toggle latch");
  property p_hold_keeps;
    @(posedge ref_clk) disable iff (sys_rst)
      (latch_sel[0] && !alt_sel[0] && release_edge[0] && is_long[0] && !wr_go)
        |=> $stable(latch[0]);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("hold changed latch");
  property p_tb2_audio;
    @(posedge ref_clk) disable iff (sys_rst)
      !cfg[CFG_TB2_EN] |-> !talkback2_active;
  endproperty
  a_tb2_audio: assert property (p_tb2_audio) else $error("disabled talkback 2 active");
  property p_relay_off;
    @(posedge ref_clk) disable iff (sys_rst)
      (relay_mode == CBR_RELAY_OFF) [*2] |-> !relay_energize;
  endproperty
  a_relay_off: assert property (p_relay_off) else $error("disabled relay energized");
  property p_relay_main;
    @(posedge ref_clk) disable iff (sys_rst)
      (relay_mode == CBR_RELAY_MAIN) |=> (relay_energize == $past(main_active));
  endproperty
  a_relay_main: assert property (p_relay_main) else $error("relay not following main");
  property p_relay_tb2;
    @(posedge ref_clk) disable iff (sys_rst)
      (relay_mode == CBR_RELAY_TB2 && pressed[2] && !latch_sel[2]) |=> relay_energize;
  endproperty
  a_relay_tb2: assert property (p_relay_tb2) else $error("relay ignored talkback 2");
  property p_reverse_dual;
    @(posedge ref_clk) disable iff (sys_rst)
      (!cfg[CFG_STEREO] && cfg[CFG_REVERSE]) |=> (hp_right_gain == $past(left_pot));
  endproperty
  a_reverse_dual: assert property (p_reverse_dual) else $error("reverse dual not swapped");

endmodule

`default_nettype wire

// >>> pkg/cbr_pkg.sv
// Constants shared by the console button and relay control block.
// Assumes a single 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package cbr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 10000;    // 100 MHz system clock.
  localparam int unsigned TICK_PERIOD_US  = 1000;     // Slow tick of 1 ms.
  localparam int unsigned TICK_CYCLES     = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned DEBOUNCE_MS     = 10;       // Button must be stable this long.
  localparam int unsigned HOLD_MS         = 400;      // Presses at least this long are holds.
  localparam int unsigned DEB_CNT_W       = 4;
  localparam int unsigned HOLD_CNT_W      = 9;
  localparam logic [DEB_CNT_W-1:0]  DEB_TICKS  = DEB_CNT_W'(DEBOUNCE_MS * 1000 / TICK_PERIOD_US);
  localparam logic [HOLD_CNT_W-1:0] HOLD_TICKS = HOLD_CNT_W'(HOLD_MS * 1000 / TICK_PERIOD_US);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CFG_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
  localparam logic [7:0]  GAIN_OFFSET    = 8'h08;
  localparam logic [9:0]  CFG_RESET      = 10'h000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Configuration field positions.
  localparam int unsigned CFG_MAIN_LSB   = 0;     // Two bits.
  localparam int unsigned CFG_TB1_HYB    = 2;
  localparam int unsigned CFG_TB2_HYB    = 3;
  localparam int unsigned CFG_TB2_EN     = 4;
  localparam int unsigned CFG_RELAY_LSB  = 6;     // Two bits.
  localparam int unsigned CFG_STEREO     = 8;
  localparam int unsigned CFG_REVERSE    = 9;
  localparam int unsigned CFG_W          = 10;

  // Rotary control width.
  localparam int unsigned POT_W          = 8;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CBR_MAIN_MUTE = 2'h0,
    CBR_MAIN_PTT  = 2'h1,
    CBR_MAIN_ALT  = 2'h2,
    CBR_MAIN_HYB  = 2'h3
  } cbr_main_mode_e;

  typedef enum logic [1:0] {
    CBR_RELAY_OFF  = 2'h0,
    CBR_RELAY_MAIN = 2'h1,
    CBR_RELAY_TB1  = 2'h2,
    CBR_RELAY_TB2  = 2'h3
  } cbr_relay_mode_e;

endpackage

// >>> tb/cbr_console_ctrl_tb_top.sv
// Self-checking bench for the console button and relay control block.
// Assumes the block's package is compiled first; drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module cbr_console_ctrl_tb_top;
  import cbr_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic             ref_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [2:0]       pins_n  = 3'h7;
  logic [POT_W-1:0] lpot    = 8'h00;
  logic [POT_W-1:0] rpot    = 8'h00;
  logic [7:0]       awaddr  = 8'h00;
  logic [7:0]       araddr  = 8'h00;
  logic [31:0]      wdata   = 32'h0;
  logic             awvalid = 1'b0;
  logic             wvalid  = 1'b0;
  logic             bready  = 1'b0;
  logic             arvalid = 1'b0;
  logic             rready  = 1'b0;
  logic [3:0]       wstrb   = 4'hF;
  logic             main_a, tb1_a, tb2_a, relay, awready, wready, bvalid, arready, rvalid;
  logic [POT_W-1:0] lg, rg;
  logic [1:0]       bresp, rresp;
  logic [31:0]      rdata;
  int               n_mismatch = 0;
  int               checked = 0;
  int               seed = 68667;
  int               cyc = 0;
  int               cfg = 0;
  int               p[3] = '{0, 0, 0};
  int               l[3] = '{0, 0, 0};
  logic [1:0]       r;
  logic [31:0]      d;

  cbr_console_ctrl #(.TICK_LEN(4)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .main_button_n(pins_n[0]), .talkback1_button_n(pins_n[1]), .talkback2_button_n(pins_n[2]),
    .left_pot(lpot), .right_pot(rpot),
    .main_active(main_a), .talkback1_active(tb1_a), .talkback2_active(tb2_a),
    .relay_energize(relay), .hp_left_gain(lg), .hp_right_gain(rg),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Clock and a watchdog; the ceiling is several times the expected run.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready and the answer are read at the rising edge that takes them, and the
  // request is dropped in that same step, so no wait state can lose it.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do @(posedge ref_clk); while (!(awready && wready));
    awvalid <= 1'b0; wvalid <= 1'b0;
    do @(posedge ref_clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    v = rdata; rs = rresp;
    rready <= 1'b0;
  endtask

  // Model of the outputs from settings, debounced presses and latches.
  task automatic check_all();
    int em, e1, es, e2, er;
    logic [31:0] st;
    @(negedge ref_clk);
    em = ((cfg & 3) == 0) ? !p[0] : ((cfg & 3) == 1) ? p[0] : ((cfg & 3) == 2) ? l[0] : p[0] | l[0];
    e1 = p[1] | (((cfg >> 2) & 1) & l[1]);
    es = (((cfg >> 4) & 1) || ((cfg >> 6) & 3) == 3) ? p[2] | (((cfg >> 3) & 1) & l[2]) : 0;
    e2 = ((cfg >> 4) & 1) & es;
    er = ((cfg >> 6) & 3) == 0 ? 0 : ((cfg >> 6) & 3) == 1 ? em : ((cfg >> 6) & 3) == 2 ? e1 : es;
    chk("main_active", main_a, 32'(em));
    chk("talkback1_active", tb1_a, 32'(e1));
    chk("talkback2_active", tb2_a, 32'(e2));
    chk("relay_energize", relay, 32'(er));
    axi_rd(STATUS_OFFSET, st, r);
    chk("status", st & 32'h71F, 32'(em | e1 << 1 | es << 2 | e2 << 3 | er << 4 |
        p[0] << 8 | p[1] << 9 | p[2] << 10));
  endtask

  // A settings write clears the latch of any button leaving a latching mode.
  task automatic set_cfg(input int c);
    if ((c & 3) < 2) l[0] = 0;
    if (((c >> 2) & 1) == 0) l[1] = 0;
    if (((c >> 3) & 1) == 0) l[2] = 0;
    cfg = c;
    axi_wr(CFG_OFFSET, 32'(c), r);
    chk("cfg_bresp", 32'(r), 32'(RESP_OKAY));
    axi_rd(CFG_OFFSET, d, r);
    chk("cfg_read", d & 32'h3FF, 32'(c));
  endtask

  function automatic int hyb(input int b);
    return (b == 0) ? int'((cfg & 3) == 3) : (cfg >> (b + 1)) & 1;
  endfunction

  // Sixty cycles cover synchronising plus ten debounce ticks of four cycles.
  task automatic btn(input int b, input int down, input int tap);
    @(posedge ref_clk);
    pins_n[b] <= !down;
    repeat (60) @(posedge ref_clk);
    p[b] = down;
    if (down && b == 0 && (cfg & 3) == 2) l[0] = 1 - l[0];
    if (!down && tap && hyb(b)) l[b] = 1 - l[b];
    check_all();
  endtask

  function automatic int fac(input int b, input int ccw);
    if (ccw) return (b <= 128) ? 255 : 2 * (255 - b);
    return (b >= 127) ? 255 : 2 * b;
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int el, er2, t;
    repeat (2) @(negedge ref_clk);
    chk("rst_main", main_a, 32'h1);
    chk("rst_tb1", tb1_a, 32'h0);
    chk("rst_tb2", tb2_a, 32'h0);
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axi_rd(CFG_OFFSET, d, r);
    chk("cfg_reset", d, 32'(CFG_RESET));
    axi_rd(8'h0C, d, r);
    chk("unmapped_rresp", 32'(r), 32'(RESP_SLVERR));
    chk("unmapped_rdata", d, 32'h0);
    axi_wr(8'h0C, 32'h1, r);
    chk("unmapped_bresp", 32'(r), 32'(RESP_SLVERR));
    axi_wr(STATUS_OFFSET, 32'hFFFFFFFF, r);
    chk("ro_bresp", 32'(r), 32'(RESP_OKAY));
    // Only the second byte lane is enabled, so only the top two bits land.
    wstrb <= 4'h2;
    axi_wr(CFG_OFFSET, 32'h3FF, r);
    axi_rd(CFG_OFFSET, d, r);
    chk("cfg_strobe", d, 32'h300);
    wstrb <= 4'hF;
    cfg = 32'h300;
    check_all();
    btn(0, 1, 0);
    set_cfg(1);
    check_all();
    btn(0, 0, 1);
    set_cfg(2);
    check_all();
    repeat (2) begin
      btn(0, 1, 1);
      btn(0, 0, 1);
    end
    @(posedge ref_clk) pins_n[0] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    btn(0, 0, 0);
    set_cfg(1);
    // Hybrid tests for all three buttons: tap latches, hold leaves it.
    for (int b = 0; b < 3; b++) begin
      set_cfg(b == 0 ? 3 : b == 1 ? 32'h04 : 32'h18);
      btn(b, 1, 1);
      btn(b, 0, 1);
      btn(b, 1, 0);
      repeat (1800) @(posedge ref_clk);
      btn(b, 0, 0);
      btn(b, 1, 1);
      btn(b, 0, 1);
    end
    // A reset in mid-run must drop a latched talkback back to muted.
    set_cfg(32'h1F);
    btn(1, 1, 1);
    btn(1, 0, 1);
    @(posedge ref_clk) sys_rst <= 1'b1;
    @(negedge ref_clk);
    chk("rst2_tb1", tb1_a, 32'h0);
    chk("rst2_main", main_a, 32'h1);
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    cfg = 0;
    l = '{0, 0, 0};
    check_all();
    set_cfg(32'h10);
    btn(2, 1, 0);
    btn(2, 0, 0);
    for (int m = 0; m < 4; m++) begin
      set_cfg(m << 6);
      btn(1, 1, 0);
      btn(2, 1, 0);
      btn(1, 0, 0);
      btn(2, 0, 0);
    end
    // Headphone mapping in all four settings with random positions.
    for (int k = 0; k < 4; k++) begin
      set_cfg((k & 1) << 8 | (k >> 1) << 9);
      for (int i = 0; i < 6; i++) begin
        @(posedge ref_clk);
        lpot <= 8'($random(seed));
        rpot <= (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($random(seed));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        el = (k & 1) ? (lpot * fac(rpot, 1)) >> 8 : lpot;
        er2 = (k & 1) ? (lpot * fac(rpot, 0)) >> 8 : rpot;
        if (k >> 1) begin
          t = el; el = er2; er2 = t;
        end
        chk("hp_left_gain", 32'(lg), 32'(el));
        chk("hp_right_gain", 32'(rg), 32'(er2));
        axi_rd(GAIN_OFFSET, d, r);
        chk("gain_read", d, 32'(er2 << 8 | el));
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
